// *** core/instruction_timing_and_flags.sv ***
// Instruction timing, flag update and interrupt gating for the two-unit core
//
// Added by the designer: the placing of the registers and register access over APB.
`timescale 1ns/1ps
module instruction_timing_and_flags (
	// APB slave
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [timing_flags_pkg::ADDR_W-1:0] paddr,
	input wire logic [timing_flags_pkg::DATA_W-1:0] pwdata,
	output logic [timing_flags_pkg::DATA_W-1:0] prdata,
	output logic pready,
	output logic pslverr,
	// Instruction issue
	input wire logic instr_valid,
	output logic instr_ready,
	input wire logic instr_unit,
	input wire timing_flags_pkg::op_class_t instr_op,
	input wire logic instr_skip,
	input wire logic [timing_flags_pkg::FLAG_W-1:0] alu_flags,
	input wire logic [timing_flags_pkg::ACC_W-1:0] acc_in,
	input wire logic [timing_flags_pkg::PC_W-1:0] pc_first,
	output logic instr_done,
	output logic instr_done_unit,
	// Flags and context restore
	output logic [timing_flags_pkg::FLAG_W-1:0] flags_first,
	output logic [timing_flags_pkg::FLAG_W-1:0] flags_second,
	output logic [timing_flags_pkg::ACC_W-1:0] acc_restore,
	output logic acc_restore_valid,
	output logic acc_restore_unit,
	// Interrupt path to the first unit
	input wire logic [timing_flags_pkg::IRQ_W-1:0] irq_event,
	output logic irq_take,
	output logic [timing_flags_pkg::PC_W-1:0] ret_addr,
	output logic resume_valid,
	output logic [timing_flags_pkg::PC_W-1:0] resume_pc,
	output logic global_irq_en
);

	// Cycle count of an instruction class
	function automatic logic is_two_cycle(input timing_flags_pkg::op_class_t op,
		input logic dual, input logic skip);
		logic r;
		r = 1'b0;
		unique case (op)
			timing_flags_pkg::op_ldtab,
			timing_flags_pkg::op_idxm: r = 1'b1;
			timing_flags_pkg::op_goto,
			timing_flags_pkg::op_call: r = !dual;
			timing_flags_pkg::op_skip_arith,
			timing_flags_pkg::op_skip_bit: r = !dual && skip;
			default: r = 1'b0;
		endcase
		return r;
	endfunction

	// Which flags an instruction class writes
	function automatic logic [timing_flags_pkg::FLAG_W-1:0] flag_mask(
		input timing_flags_pkg::op_class_t op);
		logic [timing_flags_pkg::FLAG_W-1:0] m;
		m = timing_flags_pkg::MASK_NONE;
		unique case (op)
			timing_flags_pkg::op_arith,
			timing_flags_pkg::op_skip_arith: m = timing_flags_pkg::MASK_ALL;
			timing_flags_pkg::op_logic_z,
			timing_flags_pkg::op_load_z: m = timing_flags_pkg::MASK_Z;
			timing_flags_pkg::op_shift_c,
			timing_flags_pkg::op_swapc: m = timing_flags_pkg::MASK_C;
			default: m = timing_flags_pkg::MASK_NONE;
		endcase
		return m;
	endfunction

	// Register byte address match
	function automatic logic hit(input logic [timing_flags_pkg::ADDR_W-1:0] a,
		input logic [timing_flags_pkg::ADDR_W-1:0] ofs);
		return a == ofs;
	endfunction

	logic dual_ff;
	logic gie_ff;
	logic busy_ff;
	logic busy_unit_ff;
	logic done_ff;
	logic done_unit_ff;
	logic take_ff;
	logic [timing_flags_pkg::IRQ_W-1:0] irq_enable_reg;
	logic [timing_flags_pkg::IRQ_W-1:0] irq_pending_reg;
	logic [timing_flags_pkg::FLAG_W-1:0] flags_ff [2];
	logic [timing_flags_pkg::STACK_W-1:0] stack_ff [2][timing_flags_pkg::STACK_DEPTH];
	logic [timing_flags_pkg::SP_W-1:0] sp_ff [2];
	logic [timing_flags_pkg::ACC_W-1:0] acc_out_ff;
	logic acc_valid_ff;
	logic acc_unit_ff;
	logic [timing_flags_pkg::PC_W-1:0] ret_addr_ff;
	logic resume_ff;
	logic [timing_flags_pkg::PC_W-1:0] resume_pc_ff;
	logic [timing_flags_pkg::DATA_W-1:0] prdata_ff;

	logic wr_en;
	logic rd_en;
	logic mapped;
	logic irq_req;
	logic unit_sel;
	logic accept;
	logic nxt_two;
	logic [timing_flags_pkg::FLAG_W-1:0] nxt_mask;
	logic [timing_flags_pkg::SP_W-1:0] cur_sp;
	logic [timing_flags_pkg::SP_W-1:0] nxt_pop_idx;
	logic [timing_flags_pkg::STACK_W-1:0] pop_word;

	assign wr_en = psel && penable && pwrite;
	assign rd_en = psel && !penable && !pwrite;
	assign mapped = hit(paddr, timing_flags_pkg::OFS_IRQ_ENABLE)
		|| hit(paddr, timing_flags_pkg::OFS_IRQ_PENDING)
		|| hit(paddr, timing_flags_pkg::OFS_CTRL)
		|| hit(paddr, timing_flags_pkg::OFS_STATUS)
		|| hit(paddr, timing_flags_pkg::OFS_RET_ADDR);
	assign pready = 1'b1;
	assign pslverr = psel && penable && !mapped;
	assign prdata = prdata_ff;

	// Single unit mode folds every issue onto the first unit
	assign unit_sel = dual_ff ? instr_unit : 1'b0;
	// Request only at an instruction boundary with no issue underway
	assign irq_req = gie_ff && |(irq_enable_reg & irq_pending_reg) && !busy_ff;
	// Only the first unit is held off while an interrupt is taken
	assign instr_ready = !busy_ff && !(irq_req && !unit_sel);
	assign accept = instr_valid && instr_ready;
	assign nxt_two = is_two_cycle(instr_op, dual_ff, instr_skip);
	assign nxt_mask = flag_mask(instr_op);
	assign cur_sp = sp_ff[unit_sel];
	assign nxt_pop_idx = cur_sp - timing_flags_pkg::SP_ONE;
	assign pop_word = stack_ff[unit_sel][nxt_pop_idx[1:0]];

	// APB control register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dual_ff <= timing_flags_pkg::CTRL_DUAL_RST;
		end else if (wr_en && hit(paddr, timing_flags_pkg::OFS_CTRL)) begin
			dual_ff <= pwdata[timing_flags_pkg::CTRL_DUAL_BIT];
		end
	end

	// Enable and pending carry no reset value
	always_ff @(posedge pclk) begin
		if (wr_en && hit(paddr, timing_flags_pkg::OFS_IRQ_ENABLE)) begin
			irq_enable_reg <= pwdata[timing_flags_pkg::IRQ_W-1:0];
		end
	end

	// New events win over a software write
	always_ff @(posedge pclk) begin
		if (wr_en && hit(paddr, timing_flags_pkg::OFS_IRQ_PENDING)) begin
			irq_pending_reg <= pwdata[timing_flags_pkg::IRQ_W-1:0] | irq_event;
		end else begin
			irq_pending_reg <= irq_pending_reg | irq_event;
		end
	end

	// APB read data
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_ff <= '0;
		end else if (rd_en) begin
			prdata_ff <= '0;
			if (hit(paddr, timing_flags_pkg::OFS_IRQ_ENABLE)) begin
				prdata_ff[timing_flags_pkg::IRQ_W-1:0] <= irq_enable_reg;
			end
			if (hit(paddr, timing_flags_pkg::OFS_IRQ_PENDING)) begin
				prdata_ff[timing_flags_pkg::IRQ_W-1:0] <= irq_pending_reg;
			end
			if (hit(paddr, timing_flags_pkg::OFS_CTRL)) begin
				prdata_ff[timing_flags_pkg::CTRL_DUAL_BIT] <= dual_ff;
			end
			if (hit(paddr, timing_flags_pkg::OFS_STATUS)) begin
				prdata_ff[timing_flags_pkg::STAT_GIE_BIT] <= gie_ff;
				prdata_ff[timing_flags_pkg::STAT_BUSY_BIT] <= busy_ff;
				prdata_ff[timing_flags_pkg::STAT_FLAGS0_LSB +: timing_flags_pkg::FLAG_W] <= flags_ff[0];
				prdata_ff[timing_flags_pkg::STAT_FLAGS1_LSB +: timing_flags_pkg::FLAG_W] <= flags_ff[1];
				prdata_ff[timing_flags_pkg::STAT_SP0_LSB +: timing_flags_pkg::SP_W] <= sp_ff[0];
				prdata_ff[timing_flags_pkg::STAT_SP1_LSB +: timing_flags_pkg::SP_W] <= sp_ff[1];
			end
			if (hit(paddr, timing_flags_pkg::OFS_RET_ADDR)) begin
				prdata_ff[timing_flags_pkg::PC_W-1:0] <= ret_addr_ff;
			end
		end
	end

	// Issue timing: second cycle of a two-cycle instruction
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			busy_ff <= 1'b0;
			busy_unit_ff <= 1'b0;
		end else if (busy_ff) begin
			busy_ff <= 1'b0;
		end else if (accept) begin
			busy_ff <= nxt_two;
			busy_unit_ff <= unit_sel;
		end
	end

	// Completion pulse and its unit
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			done_ff <= 1'b0;
			done_unit_ff <= 1'b0;
		end else if (busy_ff) begin
			done_ff <= 1'b1;
			done_unit_ff <= busy_unit_ff;
		end else if (accept) begin
			done_ff <= !nxt_two;
			done_unit_ff <= unit_sel;
		end else begin
			done_ff <= 1'b0;
		end
	end

	// Global enable for the first unit
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			gie_ff <= 1'b0;
		end else if (irq_req) begin
			gie_ff <= 1'b0;
		end else if (accept && !unit_sel) begin
			if (instr_op == timing_flags_pkg::op_engint) begin
				gie_ff <= 1'b1;
			end else if (instr_op == timing_flags_pkg::op_disgint) begin
				gie_ff <= 1'b0;
			end else if (instr_op == timing_flags_pkg::op_reti) begin
				gie_ff <= 1'b1;
			end
		end
	end

	// Interrupt entry pulse for the first unit
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			take_ff <= 1'b0;
		end else begin
			take_ff <= irq_req;
		end
	end

	// Return address saved on interrupt entry
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ret_addr_ff <= '0;
		end else if (irq_req) begin
			ret_addr_ff <= pc_first;
		end
	end

	// Return from interrupt resumes at the saved address
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			resume_ff <= 1'b0;
		end else begin
			resume_ff <= accept && !unit_sel && instr_op == timing_flags_pkg::op_reti;
		end
	end

	// Resume address follows the saved return address
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			resume_pc_ff <= '0;
		end else begin
			resume_pc_ff <= ret_addr_ff;
		end
	end

	// Flag registers, one set per unit
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flags_ff[0] <= timing_flags_pkg::FLAGS_RST;
			flags_ff[1] <= timing_flags_pkg::FLAGS_RST;
		end else if (accept) begin
			if (instr_op == timing_flags_pkg::op_popaf) begin
				if (cur_sp != timing_flags_pkg::SP_EMPTY) begin
					flags_ff[unit_sel] <= pop_word[timing_flags_pkg::FLAG_W-1:0];
				end
			end else begin
				flags_ff[unit_sel] <= (flags_ff[unit_sel] & ~nxt_mask)
					| (alu_flags & nxt_mask);
			end
		end
	end

	// Context stack pointer
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sp_ff[0] <= timing_flags_pkg::SP_EMPTY;
			sp_ff[1] <= timing_flags_pkg::SP_EMPTY;
		end else if (accept) begin
			if (instr_op == timing_flags_pkg::op_pushaf && cur_sp != timing_flags_pkg::SP_FULL) begin
				sp_ff[unit_sel] <= cur_sp + timing_flags_pkg::SP_ONE;
			end else if (instr_op == timing_flags_pkg::op_popaf
				&& cur_sp != timing_flags_pkg::SP_EMPTY) begin
				sp_ff[unit_sel] <= nxt_pop_idx;
			end
		end
	end

	// Context stack storage holds accumulator above flags
	always_ff @(posedge pclk) begin
		if (accept && instr_op == timing_flags_pkg::op_pushaf
			&& cur_sp != timing_flags_pkg::SP_FULL) begin
			stack_ff[unit_sel][cur_sp[1:0]] <= {acc_in, flags_ff[unit_sel]};
		end
	end

	// Accumulator restore output
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			acc_out_ff <= '0;
			acc_valid_ff <= 1'b0;
			acc_unit_ff <= 1'b0;
		end else begin
			acc_valid_ff <= 1'b0;
			if (accept && instr_op == timing_flags_pkg::op_popaf
				&& cur_sp != timing_flags_pkg::SP_EMPTY) begin
				acc_out_ff <= pop_word[timing_flags_pkg::STACK_W-1:timing_flags_pkg::FLAG_W];
				acc_valid_ff <= 1'b1;
				acc_unit_ff <= unit_sel;
			end
		end
	end

	assign instr_done = done_ff;
	assign instr_done_unit = done_unit_ff;
	assign flags_first = flags_ff[0];
	assign flags_second = flags_ff[1];
	assign acc_restore = acc_out_ff;
	assign acc_restore_valid = acc_valid_ff;
	assign acc_restore_unit = acc_unit_ff;
	assign irq_take = take_ff;
	assign ret_addr = ret_addr_ff;
	assign resume_valid = resume_ff;
	assign resume_pc = resume_pc_ff;
	assign global_irq_en = gie_ff;

endmodule

// *** common/timing_flags_pkg.sv ***
// Constants, opcode classes and register map for the timing and flag block
// Contract
// - Dual unit: table reads, indirect move two cycles
// - Single unit: jumps, calls, tables, indirect two cycles
// - Single unit: skip takes two cycles when skipping
// - Single unit: everything else takes one cycle
// - Arithmetic, compares, counting skips update four flags
// - Logic, loads, not, negate update zero only
// - Shifts and bit swap change carry only
// - Interrupts reach only the first unit
// - Global off blocks every interrupt request
// - Global on lets enabled pending requests divert
// - Save and restore accumulator with flags
// - Enable and pending registers undefined after reset
// - Return from interrupt resumes, re-enables, keeps flags
package timing_flags_pkg;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int IRQ_W = 8;
	localparam int ACC_W = 8;
	localparam int PC_W = 12;
	localparam int FLAG_W = 4;
	localparam int STACK_DEPTH = 4;
	localparam int SP_W = 3;
	localparam int STACK_W = ACC_W + FLAG_W;

	localparam logic [ADDR_W-1:0] OFS_IRQ_ENABLE = 8'h00;
	localparam logic [ADDR_W-1:0] OFS_IRQ_PENDING = 8'h04;
	localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h08;
	localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h0c;
	localparam logic [ADDR_W-1:0] OFS_RET_ADDR = 8'h10;

	localparam int CTRL_DUAL_BIT = 0;
	localparam logic CTRL_DUAL_RST = 1'h1;

	localparam int FLAG_Z = 0;
	localparam int FLAG_C = 1;
	localparam int FLAG_AC = 2;
	localparam int FLAG_OV = 3;
	localparam logic [FLAG_W-1:0] FLAGS_RST = 4'h0;
	localparam logic [FLAG_W-1:0] MASK_ALL = 4'hf;
	localparam logic [FLAG_W-1:0] MASK_Z = 4'h1;
	localparam logic [FLAG_W-1:0] MASK_C = 4'h2;
	localparam logic [FLAG_W-1:0] MASK_NONE = 4'h0;

	localparam int STAT_GIE_BIT = 0;
	localparam int STAT_BUSY_BIT = 1;
	localparam int STAT_FLAGS0_LSB = 4;
	localparam int STAT_FLAGS1_LSB = 8;
	localparam int STAT_SP0_LSB = 12;
	localparam int STAT_SP1_LSB = 16;

	localparam logic [SP_W-1:0] SP_EMPTY = 3'h0;
	localparam logic [SP_W-1:0] SP_FULL = 3'h4;
	localparam logic [SP_W-1:0] SP_ONE = 3'h1;

	typedef enum logic [4:0] {
		op_other,
		op_move,
		op_goto,
		op_call,
		op_ldtab,
		op_idxm,
		op_skip_arith,
		op_skip_bit,
		op_arith,
		op_logic_z,
		op_load_z,
		op_xor_io,
		op_shift_c,
		op_swapc,
		op_pushaf,
		op_popaf,
		op_engint,
		op_disgint,
		op_reti
	} op_class_t;
endpackage

// *** verification/instruction_timing_and_flags_chk.sv ***
// Checker for issue timing, flag merge and interrupt gating
`timescale 1ns/1ps
module instruction_timing_and_flags_chk (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Issue side
	input wire logic instr_valid,
	input wire logic instr_ready,
	input wire logic instr_unit,
	input wire timing_flags_pkg::op_class_t instr_op,
	input wire logic [3:0] alu_flags,
	input wire logic [11:0] pc_first,
	input wire logic instr_done,
	input wire logic [3:0] flags_first,
	// Interrupt side
	input wire logic irq_take,
	input wire logic [11:0] ret_addr,
	input wire logic resume_valid,
	input wire logic [11:0] resume_pc,
	input wire logic global_irq_en
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	wire logic tk = instr_valid && instr_ready;
	wire logic t0 = tk && !instr_unit;
	wire logic o2t = instr_op inside {timing_flags_pkg::op_ldtab, timing_flags_pkg::op_idxm};
	wire logic o1t = instr_op inside {timing_flags_pkg::op_move, timing_flags_pkg::op_arith};
	sequence s_two;
		!instr_ready ##1 instr_done;
	endsequence
	sequence s_irq;
		$past(global_irq_en) && !global_irq_en;
	endsequence
	two_cycle_a: assert property (tk && o2t |=> s_two)
		else $error("two-cycle timing wrong");
	one_cycle_a: assert property (tk && o1t |=> instr_done)
		else $error("one-cycle timing wrong");
	flags_all_a: assert property (t0 && instr_op == timing_flags_pkg::op_arith |=>
		flags_first == $past(alu_flags)) else $error("arith flags wrong");
	flags_z_a: assert property (t0 && instr_op == timing_flags_pkg::op_logic_z |=>
		flags_first == {$past(flags_first[3:1]), $past(alu_flags[0])})
		else $error("zero flag wrong");
	flags_c_a: assert property (t0 && instr_op == timing_flags_pkg::op_shift_c |=>
		flags_first == {$past(flags_first[3:2]), $past(alu_flags[1]), $past(flags_first[0])})
		else $error("carry flag wrong");
	flags_keep_a: assert property (t0 && instr_op == timing_flags_pkg::op_xor_io |=>
		$stable(flags_first)) else $error("flags changed");
	irq_gate_a: assert property (irq_take |-> s_irq)
		else $error("interrupt taken while disabled");
	ret_save_a: assert property (irq_take |-> ret_addr == $past(pc_first))
		else $error("return address wrong");
	reti_resume_a: assert property (t0 && instr_op == timing_flags_pkg::op_reti |=>
		resume_valid && global_irq_en && resume_pc == ret_addr) else $error("resume wrong");
endmodule
bind instruction_timing_and_flags instruction_timing_and_flags_chk u_chk (
	.pclk(pclk), .presetn(presetn), .instr_valid(instr_valid), .instr_ready(instr_ready),
	.instr_unit(instr_unit), .instr_op(instr_op), .alu_flags(alu_flags), .pc_first(pc_first),
	.instr_done(instr_done), .flags_first(flags_first), .irq_take(irq_take),
	.ret_addr(ret_addr), .resume_valid(resume_valid), .resume_pc(resume_pc),
	.global_irq_en(global_irq_en));

// *** verification/instruction_timing_and_flags_bench.sv ***
// Self-checking bench for the timing and flag block
`timescale 1ns/1ps
module instruction_timing_and_flags_bench;
	typedef struct {int due; logic u; logic [3:0] f;} note_t;
	logic pclk, presetn, psel, penable, pwrite, instr_valid, instr_unit, instr_skip;
	logic pready, pslverr, instr_ready, instr_done, instr_done_unit, irq_take, resume_valid;
	logic acc_restore_valid, acc_restore_unit, global_irq_en, erv, dual, exp_au;
	logic [7:0] paddr, acc_in, irq_event, acc_restore, exp_acc;
	logic [31:0] pwdata, prdata, rdv;
	logic [3:0] alu_flags, flags_first, flags_second;
	logic [3:0] ef [2];
	logic [11:0] pc_first, ret_addr, resume_pc, pcv;
	logic [11:0] stk [$];
	timing_flags_pkg::op_class_t instr_op;
	int failures, samples_checked, cyc, ntake, nres;
	note_t nw;
	note_t notes [$];
	instruction_timing_and_flags u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .instr_valid(instr_valid),
		.instr_ready(instr_ready), .instr_unit(instr_unit), .instr_op(instr_op),
		.instr_skip(instr_skip), .alu_flags(alu_flags), .acc_in(acc_in), .pc_first(pc_first),
		.instr_done(instr_done), .instr_done_unit(instr_done_unit), .flags_first(flags_first),
		.flags_second(flags_second), .acc_restore(acc_restore),
		.acc_restore_valid(acc_restore_valid), .acc_restore_unit(acc_restore_unit),
		.irq_event(irq_event), .irq_take(irq_take), .ret_addr(ret_addr),
		.resume_valid(resume_valid), .resume_pc(resume_pc), .global_irq_en(global_irq_en));
	task automatic print_verdict;
		if (failures == 0 && samples_checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic timeout;
		failures++;
		print_verdict();
	endtask
	task automatic check(string what, logic [31:0] exp, logic [31:0] got);
		samples_checked++;
		if (got !== exp) begin
			failures++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic apb(logic wr, logic [7:0] a, logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		{psel, pwrite, paddr, pwdata, penable} <= {1'b1, wr, a, d, 1'b0};
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1 && n < 50) begin
			@(posedge pclk);
			n++;
		end
		if (n >= 50)
			timeout();
		rdv = prdata;
		erv = pslverr;
		{psel, penable} <= 2'h0;
	endtask
	task automatic issue(logic u, timing_flags_pkg::op_class_t op, logic sk, logic gap);
		int n, lat;
		logic ue;
		logic [3:0] nf;
		logic [7:0] av;
		n = 0;
		nf = $urandom;
		av = $urandom;
		{instr_valid, instr_unit, instr_op, instr_skip} <= {1'b1, u, op, sk};
		alu_flags <= nf;
		acc_in <= av;
		@(posedge pclk);
		while (instr_ready !== 1'b1 && n < 50) begin
			@(posedge pclk);
			n++;
		end
		if (n >= 50)
			timeout();
		ue = dual & u;
		lat = (op inside {timing_flags_pkg::op_ldtab, timing_flags_pkg::op_idxm}) ? 2 : 1;
		if (!dual && (op inside {timing_flags_pkg::op_goto, timing_flags_pkg::op_call} ||
			(sk && op inside {timing_flags_pkg::op_skip_arith, timing_flags_pkg::op_skip_bit})))
			lat = 2;
		case (op)
			timing_flags_pkg::op_arith, timing_flags_pkg::op_skip_arith: ef[ue] = nf;
			timing_flags_pkg::op_logic_z, timing_flags_pkg::op_load_z: ef[ue][0] = nf[0];
			timing_flags_pkg::op_shift_c, timing_flags_pkg::op_swapc: ef[ue][1] = nf[1];
			timing_flags_pkg::op_pushaf: if (stk.size() < 4) stk.push_back({av, ef[ue]});
			timing_flags_pkg::op_popaf: if (stk.size() > 0) begin
				{exp_acc, ef[ue]} = stk.pop_back();
				exp_au = ue;
			end
			default: ;
		endcase
		notes.push_back('{cyc + lat, ue, ef[ue]});
		if (gap) begin
			instr_valid <= 1'b0;
			@(posedge pclk);
		end
	endtask
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end
	initial begin
		repeat (50000) @(posedge pclk);
		timeout();
	end
	always @(posedge pclk) cyc <= cyc + 1;
	always @(negedge pclk) begin
		if (instr_done === 1'b1) begin
			nw = notes.size() > 0 ? notes.pop_front() : '{0, 1'b0, 4'h0};
			check("done cycle", nw.due, cyc);
			check("done unit", nw.u, instr_done_unit);
			check("flags", nw.f, nw.u ? flags_second : flags_first);
		end
		if (acc_restore_valid === 1'b1) begin
			check("acc restore", exp_acc, acc_restore);
			check("acc unit", exp_au, acc_restore_unit);
		end
		if (irq_take === 1'b1)
			ntake++;
		if (resume_valid === 1'b1)
			nres++;
	end
	initial begin
		{psel, penable, pwrite, instr_valid, instr_unit, instr_skip, presetn} = '0;
		{paddr, pwdata, alu_flags, acc_in, pc_first, irq_event} = '0;
		instr_op = timing_flags_pkg::op_other;
		ef = '{4'h0, 4'h0};
		dual = 1'b1;
		void'($urandom(32'h3873));
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, 8'h08, 32'h0);
		check("ctrl reset", 32'h1, rdv);
		apb(1'b0, 8'h20, 32'h0);
		check("unmapped data", 32'h0, rdv);
		check("unmapped err", 32'h1, erv);
		for (int i = 0; i < 60; i++)
			issue(i[0], timing_flags_pkg::op_class_t'($urandom_range(13)), $urandom, 1'b0);
		instr_valid <= 1'b0;
		dual = 1'b0;
		apb(1'b1, 8'h08, 32'h0);
		for (int i = 0; i < 60; i++)
			issue($urandom, timing_flags_pkg::op_class_t'($urandom_range(13)), $urandom, 1'b1);
		for (int i = 0; i < 5; i++) begin
			issue(1'b0, timing_flags_pkg::op_arith, 1'b0, 1'b1);
			issue(1'b0, timing_flags_pkg::op_pushaf, 1'b0, 1'b1);
		end
		for (int i = 0; i < 5; i++)
			issue(1'b0, timing_flags_pkg::op_popaf, 1'b0, 1'b1);
		pcv = $urandom;
		pc_first <= pcv;
		apb(1'b1, 8'h00, 32'h1);
		apb(1'b1, 8'h04, 32'h0);
		issue(1'b0, timing_flags_pkg::op_engint, 1'b0, 1'b1);
		issue(1'b0, timing_flags_pkg::op_disgint, 1'b0, 1'b1);
		irq_event <= 8'h01;
		@(posedge pclk);
		irq_event <= 8'h00;
		repeat (4) @(posedge pclk);
		check("no take", 0, ntake);
		issue(1'b0, timing_flags_pkg::op_engint, 1'b0, 1'b1);
		repeat (4) @(posedge pclk);
		check("take", 1, ntake);
		check("gie off", 1'b0, global_irq_en);
		check("ret addr", pcv, ret_addr);
		apb(1'b0, 8'h10, 32'h0);
		check("ret reg", {20'h0, pcv}, rdv);
		apb(1'b0, 8'h00, 32'h0);
		check("enable reg", 32'h1, rdv);
		apb(1'b1, 8'h04, 32'h0);
		issue(1'b0, timing_flags_pkg::op_reti, 1'b0, 1'b1);
		check("gie on", 1'b1, global_irq_en);
		check("resume pc", pcv, resume_pc);
		check("resume pulse", 1, nres);
		repeat (5) @(posedge pclk);
		check("notes left", 0, notes.size());
		print_verdict();
	end
endmodule
